// [rtl/pcm_slot_pkg.sv]
// constants and carrier types for the pcm slot port and interface latches
package pcm_slot_pkg;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int          LATCH_W       = 6;
  localparam int          SLOT_W        = 6;
  localparam int          POS_W         = 10;
  localparam int          BITS_PER_SLOT = 8;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  localparam logic [4:0]  CTL_CMD_LAST  = 5'h07;
  localparam logic [4:0]  CTL_DATA_FST  = 5'h08;
  localparam logic [4:0]  CTL_DATA_LAST = 5'h0f;
  localparam logic [4:0]  CTL_DONE      = 5'h10;

  // ****************************************
  // control command byte and register map
  // ****************************************
  localparam int          CMD_READ_BIT  = 7;
  localparam logic [2:0]  REG_MODE      = 3'h0;
  localparam logic [2:0]  REG_TX_SLOT   = 3'h1;
  localparam logic [2:0]  REG_RX_SLOT   = 3'h2;
  localparam logic [2:0]  REG_LATCH_DIR = 3'h3;
  localparam logic [2:0]  REG_LATCH_DAT = 3'h4;
  localparam int          MODE_DELAYED  = 0;
  localparam int          MODE_TX_PORT  = 1;
  localparam int          MODE_RX_PORT  = 2;
  localparam int          MODE_TX_EN    = 3;
  localparam int          MODE_RX_EN    = 4;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]  LATCH_DIR_RST = 8'h00;
  localparam logic [7:0]  LATCH_DAT_RST = 8'h00;

  typedef struct packed {
    logic              delayed;
    logic              tx_port;
    logic              rx_port;
    logic              tx_en;
    logic              rx_en;
    logic [SLOT_W-1:0] tx_slot;
    logic [SLOT_W-1:0] rx_slot;
  } cfg_t;

  localparam cfg_t CFG_RST = '0;

endpackage

// [rtl/pcm_slot_port_and_latches.sv]
// pcm time-slot port, serial control port and interface latches
`timescale 1ns/100ps
`default_nettype none
module pcm_slot_port_and_latches #(
  parameter int LATCH_W   = pcm_slot_pkg::LATCH_W,
  parameter bit SHARED_IO = 1'b0
) (
  input  wire logic               i_clk,
  input  wire logic               i_srst,
  input  wire logic               i_bit_clk,
  input  wire logic               i_tx_frame_sync,
  input  wire logic               i_rx_frame_sync,
  input  wire logic               i_rx_pcm_in_port0,
  input  wire logic               i_rx_pcm_in_port1,
  output logic                    o_tx_pcm_out_port0,
  output logic                    o_tx_pcm_out_port0_oe_n,
  output logic                    o_tx_pcm_out_port1,
  output logic                    o_tx_pcm_out_port1_oe_n,
  output logic                    o_tx_slot_active_n_port0,
  output logic                    o_tx_slot_active_n_port0_oe_n,
  output logic                    o_tx_slot_active_n_port1,
  output logic                    o_tx_slot_active_n_port1_oe_n,
  input  wire logic               i_control_shift_clock,
  input  wire logic               i_chip_select_n,
  input  wire logic               i_control_serial_in,
  output logic                    o_control_serial_out,
  output logic                    o_control_serial_out_oe_n,
  input  wire logic               i_control_serial_bidir,
  output logic                    o_control_serial_bidir,
  output logic                    o_control_serial_bidir_oe_n,
  input  wire logic [LATCH_W-1:0] i_slic_latch_pin,
  output logic      [LATCH_W-1:0] o_slic_latch_pin,
  output logic      [LATCH_W-1:0] o_slic_latch_pin_oe_n,
  input  wire logic [7:0]         i_tx_pcm_byte,
  input  wire logic               i_tx_pcm_valid,
  output logic      [7:0]         o_rx_pcm_byte,
  output logic                    o_rx_pcm_valid
);

  if (LATCH_W < 1 || LATCH_W > 8)
  begin : g_bad_width
    $error("LATCH_W must be 1 to 8");
  end

  localparam int          SW   = pcm_slot_pkg::SLOT_W;
  localparam int          PW   = pcm_slot_pkg::POS_W;
  localparam logic [PW-1:0] PMAX = '1;

  // ****************************************
  // helpers
  // ****************************************
  // position counter restarts at the sync edge and saturates so a lost sync
  // never reopens a slot by wrapping
  function automatic logic [PW-1:0] next_pos(input logic st, input logic [PW-1:0] p);
    next_pos = st ? '0 : ((p == PMAX) ? p : PW'(p + 1'b1));
  endfunction

  function automatic logic in_slot(input logic [PW-1:0] p, input logic dly,
                                   input logic [SW-1:0] slot);
    logic [PW-1:0] base;
    base = dly ? PW'({slot, 3'h0}) : '0;
    in_slot = (p >= base) && (p < PW'(base + PW'(pcm_slot_pkg::BITS_PER_SLOT)));
  endfunction

  // ****************************************
  // pin synchronisers, system clock
  // ****************************************
  localparam int NS = LATCH_W + 4;
  logic [NS-1:0] pin_s1_q;
  logic [NS-1:0] pin_s2_q;
  always_ff @(posedge i_clk)
  begin
    pin_s1_q <= {i_slic_latch_pin, i_control_serial_bidir, i_control_serial_in,
                 i_chip_select_n, i_control_shift_clock};
    pin_s2_q <= pin_s1_q;
  end

  wire               control_shift_clock_s   = pin_s2_q[0];
  wire               cs_n_s   = pin_s2_q[1];
  wire               cdin_s   = SHARED_IO ? pin_s2_q[3] : pin_s2_q[2];
  wire [LATCH_W-1:0] pins_s   = pin_s2_q[NS-1:4];

  // ****************************************
  // serial control port
  // ****************************************
  // the control clock is oversampled, so any phase or rate relation to the
  // bit clock works as long as each control clock level lasts two system clocks
  // no reset value: it tracks the pin, so no false edge follows reset
  logic control_shift_clock_prev_q;
  always_ff @(posedge i_clk)
    control_shift_clock_prev_q <= control_shift_clock_s;

  wire cfall = control_shift_clock_prev_q & ~control_shift_clock_s & ~cs_n_s;
  wire crise = ~control_shift_clock_prev_q & control_shift_clock_s & ~cs_n_s;

  logic [4:0]         cbit_q;
  logic [7:0]         cin_q;
  logic [7:0]         cmd_q;
  logic [7:0]         cout_sh_q;
  logic               cout_q;
  logic               cdrive_q;
  pcm_slot_pkg::cfg_t cfg_q;
  logic [7:0]         ldir_q;
  logic [7:0]         ldat_q;

  wire [7:0] cin_d      = {cin_q[6:0], cdin_s};
  wire       cmd_done   = cfall & (cbit_q == pcm_slot_pkg::CTL_CMD_LAST);
  wire       is_read    = cmd_q[pcm_slot_pkg::CMD_READ_BIT];
  wire       new_read   = cin_d[pcm_slot_pkg::CMD_READ_BIT];
  wire       data_done  = cfall & ~is_read & (cbit_q == pcm_slot_pkg::CTL_DATA_LAST);
  wire [2:0] new_addr   = cin_d[2:0];
  wire [2:0] addr       = cmd_q[2:0];
  wire       shift_out  = crise & is_read & (cbit_q >= pcm_slot_pkg::CTL_DATA_FST) &
                          (cbit_q <= pcm_slot_pkg::CTL_DATA_LAST);
  wire [7:0] ldir_mask  = ldir_q & 8'(({LATCH_W{1'b1}}));
  wire [7:0] pins_w     = 8'(pins_s);

  // input-direction bits follow the pins, output-direction bits keep their data
  wire [7:0] ldat_cap   = (ldat_q & ldir_mask) | (pins_w & ~ldir_mask);
  wire [7:0] ldat_wr    = (cin_d & ldir_mask) | (pins_w & ~ldir_mask);

  wire [7:0] mode_rd = {3'h0, cfg_q.rx_en, cfg_q.tx_en, cfg_q.rx_port,
                        cfg_q.tx_port, cfg_q.delayed};
  wire [7:0] rd_data = (new_addr == pcm_slot_pkg::REG_MODE)      ? mode_rd :
                       (new_addr == pcm_slot_pkg::REG_TX_SLOT)   ? 8'(cfg_q.tx_slot) :
                       (new_addr == pcm_slot_pkg::REG_RX_SLOT)   ? 8'(cfg_q.rx_slot) :
                       (new_addr == pcm_slot_pkg::REG_LATCH_DIR) ? ldir_mask :
                       (new_addr == pcm_slot_pkg::REG_LATCH_DAT) ? ldat_cap : 8'h00;

  always_ff @(posedge i_clk)
  begin
    if (i_srst || cs_n_s)
      cbit_q <= '0;
    else if (cfall && cbit_q != pcm_slot_pkg::CTL_DONE)
      cbit_q <= cbit_q + 5'h01;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cin_q <= '0;
      cmd_q <= '0;
    end
    else if (cfall)
    begin
      cin_q <= cin_d;
      if (cmd_done)
        cmd_q <= cin_d;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      cout_sh_q <= '0;
    else if (cmd_done && new_read)
      cout_sh_q <= rd_data;
    else if (shift_out)
      cout_sh_q <= {cout_sh_q[6:0], 1'b0};
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst || cs_n_s)
    begin
      cout_q   <= 1'b0;
      cdrive_q <= 1'b0;
    end
    else if (shift_out)
    begin
      cout_q   <= cout_sh_q[7];
      cdrive_q <= 1'b1;
    end
  end

  // ****************************************
  // configuration and latch registers
  // ****************************************
  wire wr_mode = data_done & (addr == pcm_slot_pkg::REG_MODE);
  wire wr_txs  = data_done & (addr == pcm_slot_pkg::REG_TX_SLOT);
  wire wr_rxs  = data_done & (addr == pcm_slot_pkg::REG_RX_SLOT);
  wire wr_ldir = data_done & (addr == pcm_slot_pkg::REG_LATCH_DIR);
  wire wr_ldat = data_done & (addr == pcm_slot_pkg::REG_LATCH_DAT);

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      cfg_q <= pcm_slot_pkg::CFG_RST;
    else if (wr_mode)
    begin
      cfg_q.delayed <= cin_d[pcm_slot_pkg::MODE_DELAYED];
      cfg_q.tx_port <= cin_d[pcm_slot_pkg::MODE_TX_PORT];
      cfg_q.rx_port <= cin_d[pcm_slot_pkg::MODE_RX_PORT];
      cfg_q.tx_en   <= cin_d[pcm_slot_pkg::MODE_TX_EN];
      cfg_q.rx_en   <= cin_d[pcm_slot_pkg::MODE_RX_EN];
    end
    else if (wr_txs)
      cfg_q.tx_slot <= cin_d[SW-1:0];
    else if (wr_rxs)
      cfg_q.rx_slot <= cin_d[SW-1:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      ldir_q <= pcm_slot_pkg::LATCH_DIR_RST;
    else if (wr_ldir)
      ldir_q <= cin_d;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      ldat_q <= pcm_slot_pkg::LATCH_DAT_RST;
    else if (wr_ldat)
      ldat_q <= ldat_wr;
    else if (cmd_done)
      ldat_q <= ldat_cap;
  end

  assign o_slic_latch_pin      = ldat_q[LATCH_W-1:0];
  assign o_slic_latch_pin_oe_n = ~ldir_q[LATCH_W-1:0];

  assign o_control_serial_out        = cout_q;
  assign o_control_serial_out_oe_n   = ~(cdrive_q & ~SHARED_IO);
  assign o_control_serial_bidir      = cout_q;
  assign o_control_serial_bidir_oe_n = ~(cdrive_q & SHARED_IO);

  // ****************************************
  // pcm byte hand-over between domains
  // ****************************************
  // one byte per frame: a second valid before the slot reuses the newer byte
  logic [7:0] tx_hold_q;
  logic       tx_tgl_q;
  logic [2:0] rx_tgl_s_q;
  logic [7:0] rword_q;
  logic       rtgl_q;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      tx_hold_q <= '0;
      tx_tgl_q  <= 1'b0;
    end
    else if (i_tx_pcm_valid)
    begin
      tx_hold_q <= i_tx_pcm_byte;
      tx_tgl_q  <= ~tx_tgl_q;
    end
  end

  wire rx_new = rx_tgl_s_q[2] ^ rx_tgl_s_q[1];
  always_ff @(posedge i_clk)
  begin
    rx_tgl_s_q     <= i_srst ? 3'h0 : {rx_tgl_s_q[1:0], rtgl_q};
    o_rx_pcm_valid <= ~i_srst & rx_new;
    if (i_srst)
      o_rx_pcm_byte <= '0;
    else if (rx_new)
      o_rx_pcm_byte <= rword_q;
  end

  // ****************************************
  // bit clock domain, transmit side
  // ****************************************
  // the whole configuration word is double-registered; software changes slot
  // or port only with the direction disabled, so a torn word is never used
  logic               brst_s_q;
  logic               brst_q;
  pcm_slot_pkg::cfg_t cfg_s_q;
  pcm_slot_pkg::cfg_t cfg_b_q;
  logic [2:0]         ttgl_s_q;
  logic [7:0]         tbyte_q;

  always_ff @(posedge i_bit_clk)
  begin
    brst_s_q <= i_srst;
    brst_q   <= brst_s_q;
    cfg_s_q  <= cfg_q;
    cfg_b_q  <= cfg_s_q;
    ttgl_s_q <= {ttgl_s_q[1:0], tx_tgl_q};
    if (ttgl_s_q[2] ^ ttgl_s_q[1])
      tbyte_q <= tx_hold_q;
  end

  logic          fsx_q;
  logic [PW-1:0] tpos_q;
  logic          tx_act_q;
  logic          tx_port_q;
  logic          tx_bit_q;
  logic [7:0]    tcur_q;

  wire          tx_start = i_tx_frame_sync & ~fsx_q;
  wire [PW-1:0] tpos_d   = next_pos(tx_start, tpos_q);
  wire          tx_act_d = cfg_b_q.tx_en & in_slot(tpos_d, cfg_b_q.delayed, cfg_b_q.tx_slot);
  wire          tx_first = tx_act_d & ~tx_act_q;
  wire [7:0]    tsel     = tx_first ? tbyte_q : tcur_q;

  always_ff @(posedge i_bit_clk)
  begin
    if (brst_q)
    begin
      fsx_q     <= 1'b0;
      tpos_q    <= PMAX;
      tx_act_q  <= 1'b0;
      tx_port_q <= 1'b0;
      tx_bit_q  <= 1'b0;
      tcur_q    <= '0;
    end
    else
    begin
      fsx_q    <= i_tx_frame_sync;
      tpos_q   <= tpos_d;
      tx_act_q <= tx_act_d;
      tx_bit_q <= tx_act_d & tsel[~tpos_d[2:0]];
      if (tx_first)
      begin
        tcur_q    <= tbyte_q;
        tx_port_q <= cfg_b_q.tx_port;
      end
    end
  end

  wire drv0 = tx_act_q & ~tx_port_q;
  wire drv1 = tx_act_q & tx_port_q;

  assign o_tx_pcm_out_port0            = tx_bit_q;
  assign o_tx_pcm_out_port1            = tx_bit_q;
  assign o_tx_pcm_out_port0_oe_n       = ~drv0;
  assign o_tx_pcm_out_port1_oe_n       = ~drv1;
  assign o_tx_slot_active_n_port0      = 1'b0;
  assign o_tx_slot_active_n_port1      = 1'b0;
  assign o_tx_slot_active_n_port0_oe_n = ~drv0;
  assign o_tx_slot_active_n_port1_oe_n = ~drv1;

  // ****************************************
  // bit clock domain, receive side
  // ****************************************
  logic          fsr_q;
  logic [PW-1:0] rpos_q;
  logic [7:0]    rsh_q;

  wire          rx_start = i_rx_frame_sync & ~fsr_q;
  wire [PW-1:0] rpos_d   = next_pos(rx_start, rpos_q);
  wire          rx_act   = cfg_b_q.rx_en & in_slot(rpos_d, cfg_b_q.delayed, cfg_b_q.rx_slot);
  wire          rin      = cfg_b_q.rx_port ? i_rx_pcm_in_port1 : i_rx_pcm_in_port0;
  wire [7:0]    rsh_d    = {rsh_q[6:0], rin};

  always_ff @(negedge i_bit_clk)
  begin
    if (brst_q)
    begin
      fsr_q   <= 1'b0;
      rpos_q  <= PMAX;
      rsh_q   <= '0;
      rword_q <= '0;
      rtgl_q  <= 1'b0;
    end
    else
    begin
      fsr_q  <= i_rx_frame_sync;
      rpos_q <= rpos_d;
      if (rx_act)
        rsh_q <= rsh_d;
      if (rx_act && rpos_d[2:0] == pcm_slot_pkg::LAST_BIT)
      begin
        rword_q <= rsh_d;
        rtgl_q  <= ~rtgl_q;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_tx_idle_released: assert property (@(posedge i_bit_clk) disable iff (brst_q)
    !o_tx_pcm_out_port0_oe_n |-> in_slot(tpos_q, cfg_b_q.delayed, cfg_b_q.tx_slot))
    else $error("transmit port 0 driven outside its slot");

  a_tx_eight_edges: assert property (@(posedge i_bit_clk) disable iff (brst_q)
    $rose(tx_act_q) |-> tx_act_q [*8] ##1 !tx_act_q)
    else $error("transmit slot not eight bit clocks long");

  a_tx_msb_first: assert property (@(posedge i_bit_clk) disable iff (brst_q)
    $rose(tx_act_q) |-> tx_bit_q == tcur_q[7])
    else $error("transmit slot did not start with the byte msb");

  a_slot_ind_follows: assert property (@(posedge i_bit_clk) disable iff (brst_q)
    !o_tx_slot_active_n_port1_oe_n |-> !o_tx_slot_active_n_port1 &&
      !o_tx_pcm_out_port1_oe_n && o_tx_slot_active_n_port0_oe_n)
    else $error("slot indicator 1 active without port 1 slot");

  a_rx_capture_fall: assert property (@(negedge i_bit_clk) disable iff (brst_q)
    $changed(rtgl_q) |-> rword_q[0] == $past(rin))
    else $error("received byte lsb not from selected input");

  a_latch_reset_input: assert property (@(posedge i_clk)
    $past(i_srst) |-> &o_slic_latch_pin_oe_n)
    else $error("latch pins not inputs after reset");

  a_latch_out_data: assert property (@(posedge i_clk) disable iff (i_srst)
    $past(wr_ldat) && ldir_q[0] |-> o_slic_latch_pin[0] == $past(cin_d[0]))
    else $error("output latch pin lost written data");

  a_latch_capture_in: assert property (@(posedge i_clk) disable iff (i_srst)
    cmd_done && !ldir_q[0] |=> ldat_q[0] == $past(pins_s[0]))
    else $error("input latch level not captured on command");

  a_ctl_cs_release: assert property (@(posedge i_clk) disable iff (i_srst)
    cs_n_s |=> !cdrive_q && o_control_serial_out_oe_n)
    else $error("control output driven with chip select high");

  a_ctl_out_rise: assert property (@(posedge i_clk) disable iff (i_srst)
    $changed(cout_q) && !$past(cs_n_s) |-> $past(crise))
    else $error("control output changed off a rising control clock");

endmodule
`default_nettype wire

// [sim/pcm_far_end.sv]
// far-end highway model: frame syncs, receive data and transmit capture
`timescale 1ns/100ps
`default_nettype none
module pcm_far_end (
  input  wire logic       i_bit_clk,
  input  wire logic       i_go,
  input  wire logic       i_port,
  input  wire logic [5:0] i_start,
  input  wire logic [7:0] i_rx_byte,
  input  wire logic [1:0] i_tx_pcm,
  input  wire logic [1:0] i_tx_oe_n,
  input  wire logic [1:0] i_ts_oe_n,
  output logic            o_tx_frame_sync,
  output logic            o_rx_frame_sync,
  output logic [1:0]      o_rx_pcm_in,
  output logic            o_done,
  output logic [7:0]      o_tx_byte,
  output logic [5:0]      o_first,
  output logic [3:0]      o_cnt0,
  output logic [3:0]      o_cnt1,
  output logic [3:0]      o_ts_bad
);
  logic       act;
  logic [5:0] cnt;
  logic [5:0] rel;

  assign rel = cnt - i_start;

  initial
  begin
    act = 1'b0;
    cnt = 6'h00;
    o_tx_frame_sync = 1'b0;
    o_rx_frame_sync = 1'b0;
    o_rx_pcm_in = 2'h1;
    o_done = 1'b0;
  end

  // ****************************************
  // frame start and transmit capture
  // ****************************************
  always @(negedge i_bit_clk)
  begin
    o_tx_frame_sync <= 1'b0;
    o_rx_frame_sync <= 1'b0;
    if (!i_go)
      o_done <= 1'b0;
    if (i_go && !act && !o_done)
    begin
      // one bit clock wide, so a rising edge and then a falling edge see it
      o_tx_frame_sync <= 1'b1;
      o_rx_frame_sync <= 1'b1;
      act <= 1'b1;
      o_first <= 6'h3f;
      o_cnt0 <= 4'h0;
      o_cnt1 <= 4'h0;
      o_ts_bad <= 4'h0;
    end
    else if (act)
    begin
      if (!i_tx_oe_n[i_port])
        o_tx_byte <= {o_tx_byte[6:0], i_tx_pcm[i_port]};
      if (!i_tx_oe_n[i_port] && o_first == 6'h3f)
        o_first <= cnt - 6'h01;
      o_cnt0 <= o_cnt0 + {3'h0, ~i_tx_oe_n[0]};
      o_cnt1 <= o_cnt1 + {3'h0, ~i_tx_oe_n[1]};
      o_ts_bad <= o_ts_bad + {3'h0, i_ts_oe_n != i_tx_oe_n};
      if (cnt >= 6'h28)
      begin
        act <= 1'b0;
        o_done <= 1'b1;
      end
    end
  end

  // ****************************************
  // receive data
  // ****************************************
  always @(posedge i_bit_clk)
  begin
    // idle lines toggle so a stray sample never looks like slot data
    o_rx_pcm_in <= ~o_rx_pcm_in;
    cnt <= act ? cnt + 6'h01 : 6'h00;
    if (act)
    begin
      if (rel < 6'h08)
        o_rx_pcm_in[i_port] <= i_rx_byte[3'h7 - rel[2:0]];
    end
  end
endmodule
`default_nettype wire

// [sim/pcm_slot_port_and_latches_tb.sv]
// self-checking bench for the pcm slot port and interface latches
`timescale 1ns/100ps
`default_nettype none
module pcm_slot_port_and_latches_tb;
  logic        i_clk;
  logic        i_srst;
  logic        bit_clk;
  logic        ctl_clk;
  logic        cs_n;
  logic        ctl_in;
  logic        ctl_out;
  logic        ctl_out_oe_n;
  logic        go;
  logic        port;
  logic        done;
  logic        tx_vld;
  logic        rx_vld;
  logic        fs_tx;
  logic        fs_rx;
  logic [1:0]  rx_pcm;
  logic [1:0]  tx_pcm;
  logic [1:0]  tx_oe_n;
  logic [1:0]  ts_oe_n;
  logic [1:0]  ts_pin;
  logic        bidir_oe_n;
  logic [5:0]  pins;
  logic [5:0]  lat_out;
  logic [5:0]  lat_oe_n;
  logic [5:0]  start;
  logic [5:0]  first;
  logic [3:0]  cnt0;
  logic [3:0]  cnt1;
  logic [3:0]  ts_bad;
  logic [7:0]  tx_byte;
  logic [7:0]  tx_cap;
  logic [7:0]  rx_byte;
  logic [7:0]  rx_out;
  logic [31:0] seed = 32'h00000036;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;

  pcm_slot_port_and_latches pcm_slot_port_and_latches_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_bit_clk(bit_clk),
    .i_tx_frame_sync(fs_tx), .i_rx_frame_sync(fs_rx),
    .i_rx_pcm_in_port0(rx_pcm[0]), .i_rx_pcm_in_port1(rx_pcm[1]),
    .o_tx_pcm_out_port0(tx_pcm[0]), .o_tx_pcm_out_port0_oe_n(tx_oe_n[0]),
    .o_tx_pcm_out_port1(tx_pcm[1]), .o_tx_pcm_out_port1_oe_n(tx_oe_n[1]),
    .o_tx_slot_active_n_port0(ts_pin[0]), .o_tx_slot_active_n_port0_oe_n(ts_oe_n[0]),
    .o_tx_slot_active_n_port1(ts_pin[1]), .o_tx_slot_active_n_port1_oe_n(ts_oe_n[1]),
    .i_control_shift_clock(ctl_clk), .i_chip_select_n(cs_n), .i_control_serial_in(ctl_in),
    .o_control_serial_out(ctl_out), .o_control_serial_out_oe_n(ctl_out_oe_n),
    .i_control_serial_bidir(1'b1), .o_control_serial_bidir(),
    .o_control_serial_bidir_oe_n(bidir_oe_n),
    .i_slic_latch_pin(pins), .o_slic_latch_pin(lat_out), .o_slic_latch_pin_oe_n(lat_oe_n),
    .i_tx_pcm_byte(tx_byte), .i_tx_pcm_valid(tx_vld),
    .o_rx_pcm_byte(rx_out), .o_rx_pcm_valid(rx_vld));

  pcm_far_end pcm_far_end_inst (
    .i_bit_clk(bit_clk), .i_go(go), .i_port(port), .i_start(start), .i_rx_byte(rx_byte),
    .i_tx_pcm(tx_pcm), .i_tx_oe_n(tx_oe_n), .i_ts_oe_n(ts_oe_n),
    .o_tx_frame_sync(fs_tx), .o_rx_frame_sync(fs_rx), .o_rx_pcm_in(rx_pcm), .o_done(done),
    .o_tx_byte(tx_cap), .o_first(first), .o_cnt0(cnt0), .o_cnt1(cnt1), .o_ts_bad(ts_bad));

  // ****************************************
  // clocks and hang guard
  // ****************************************
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  initial
  begin
    bit_clk = 1'b0;
    #37;
    forever #80 bit_clk = ~bit_clk;
  end

  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wclk(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // the control clock stays low 6 system clocks and high 12, above the two the sampler needs
  task automatic ctl(input logic en, input logic [7:0] cmd, input logic [7:0] dat,
                     output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, dat};
    rd = 8'h00;
    cs_n = ~en;
    wclk(6);
    for (int i = 0; i < 16; i++)
    begin
      ctl_in = sh[15-i];
      wclk(6);
      ctl_clk = 1'b0;
      wclk(6);
      ctl_clk = 1'b1;
      wclk(6);
      if (i >= 7 && i < 15)
        rd = {rd[6:0], ctl_out};
      if (i == 10)
        chk({7'h00, ctl_out_oe_n}, {7'h00, ~(cmd[7] & en)});
      if (i == 10)
        chk({7'h00, bidir_oe_n}, 8'h01);
    end
    cs_n = 1'b1;
    wclk(10);
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] r;
    ctl(1'b1, {5'h00, a}, d, r);
  endtask

  task automatic rreg(input logic [2:0] a, output logic [7:0] r);
    ctl(1'b1, {5'h10, a}, 8'h00, r);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [7:0] dir;
    logic [7:0] dat;
    logic [7:0] rd;
    logic [7:0] slot;
    logic       got;
    i_srst = 1'b1;
    ctl_clk = 1'b1;
    cs_n = 1'b1;
    ctl_in = 1'b0;
    go = 1'b0;
    port = 1'b0;
    start = 6'h00;
    rx_byte = 8'h00;
    tx_byte = 8'h00;
    tx_vld = 1'b0;
    pins = 6'h2d;
    wclk(12);
    i_srst = 1'b0;
    // the bit clock side takes its reset two bit clocks late
    wclk(40);
    chk({2'h0, lat_oe_n}, 8'h3f);
    chk({6'h00, tx_oe_n}, 8'h03);
    for (int k = 0; k < 3; k++)
    begin
      dir = rnd() & 8'h3f;
      dat = rnd() & 8'h3f;
      wreg(pcm_slot_pkg::REG_LATCH_DIR, dir);
      wreg(pcm_slot_pkg::REG_LATCH_DAT, dat);
      chk({2'h0, ~lat_oe_n}, dir);
      chk({2'h0, lat_out} & dir, dat & dir);
      pins = 6'(rnd());
      wclk(4);
      rreg(pcm_slot_pkg::REG_LATCH_DAT, rd);
      chk(rd & 8'h3f, (dat & dir) | ({2'h0, pins} & ~dir));
      $display("test latch %0d done", k);
    end
    ctl(1'b0, {5'h00, pcm_slot_pkg::REG_LATCH_DIR}, 8'h3f, rd);
    rreg(pcm_slot_pkg::REG_LATCH_DIR, rd);
    chk(rd & 8'h3f, dir);
    rreg(3'h7, rd);
    chk(rd, 8'h00);
    $display("test control refusal done");
    for (int k = 0; k < 4; k++)
    begin
      port = k[0];
      slot = k[1] ? (rnd() & 8'h03) : 8'h00;
      start = {slot[2:0], 3'h0};
      wreg(pcm_slot_pkg::REG_MODE, 8'h00);
      wreg(pcm_slot_pkg::REG_TX_SLOT, slot);
      wreg(pcm_slot_pkg::REG_RX_SLOT, slot);
      // 8'h18 enables both directions; low bits pick the ports and the delayed mode
      wreg(pcm_slot_pkg::REG_MODE, 8'h18 | {5'h00, port, port, k[1]});
      rreg(pcm_slot_pkg::REG_MODE, rd);
      chk(rd, 8'h18 | {5'h00, port, port, k[1]});
      rreg(pcm_slot_pkg::REG_RX_SLOT, rd);
      chk(rd, slot);
      rx_byte = (k == 0) ? 8'h81 : rnd();
      tx_byte = (k == 0) ? 8'h7e : rnd();
      tx_vld = 1'b1;
      wclk(1);
      tx_vld = 1'b0;
      wclk(200);
      go = 1'b1;
      got = 1'b0;
      for (int n = 0; n < 4000 && done !== 1'b1; n++)
      begin
        @(negedge i_clk);
        if (rx_vld === 1'b1)
          got = 1'b1;
        if (rx_vld === 1'b1)
          dat = rx_out;
      end
      go = 1'b0;
      chk(tx_cap, tx_byte);
      chk({2'h0, first}, {2'h0, start});
      chk({4'h0, port ? cnt1 : cnt0}, 8'h08);
      chk({4'h0, port ? cnt0 : cnt1}, 8'h00);
      chk({4'h0, ts_bad}, 8'h00);
      chk({6'h00, ts_pin}, 8'h00);
      chk({7'h00, got}, 8'h01);
      chk(dat, rx_byte);
      $display("test pcm %0d done", k);
    end
    end_sim();
  end
endmodule
`default_nettype wire
